/* design/bms_brake_seq.sv */
// Mechanical brake sequencer inside a motor drive.
// Assumes speed, current and mode levels on this clock; async terminal pins synchronised here.
// Notes on behaviour
// - Sequence runs only with ramp mode 7 (feedback) or 8 (no feedback).
// - Sequence valid only in external, combined mode 1 or network operation.
// - Release-done is read from input terminals whose function code is 15.
// - Request drives output terminals coded 20 (positive) or 120 (inverted).
// - At speed and current thresholds, wait detect delay, then raise request.
// - Mode 7: hold frequency for start delay after release-done, then ramp.
// - Decelerating to engage frequency drops the release request.
// - Mode 7: switch output off stop delay after release-done goes inactive.
// - Release frequency 0..30 Hz, default 3 Hz, accepted only if <= engage.
// - Release current 0..200 percent, default 130 percent.
// - Detection delay 0..2 s, default 0.3 s.
// - Start brake delay 0..5 s, default 0.3 s.
// - Engage frequency 0..30 Hz, default 6 Hz.
// - Stop brake delay 0..5 s, default 0.3 s.
// - Auto restart after supply loss is inhibited in brake sequence mode.
// - Mode 8: delays counted from request raise and request drop.
// - Trip and drop request if request not raised within 2 s of start.
// - Trip and drop request if release-done absent 2 s after request.
// - Trip and drop request if release-done drops while request is on.
`timescale 1ns/1ps

module bms_brake_seq
  import bms_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BMS_TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [`BMS_MODE_W-1:0] ramp_mode_select_i,
  input wire logic op_mode_valid_i,
  input wire logic start_cmd_i,
  input wire logic decel_i,
  input wire logic [`BMS_FREQ_W-1:0] speed_cmd_i,
  input wire logic [`BMS_CUR_W-1:0] out_current_i,
  input wire logic [`BMS_N_IN-1:0] term_in_i,
  input wire logic [`BMS_N_IN*`BMS_FUNC_W-1:0] input_terminal_function_select_i,
  input wire logic [`BMS_N_OUT*`BMS_FUNC_W-1:0] output_terminal_function_select_i,
  input wire logic param_load_i,
  input wire logic [`BMS_FREQ_W-1:0] brake_release_freq_i,
  input wire logic [`BMS_FREQ_W-1:0] brake_engage_freq_i,
  input wire logic [`BMS_CUR_W-1:0] brake_release_current_i,
  input wire logic [`BMS_DLY_W-1:0] release_current_detect_delay_i,
  input wire logic [`BMS_DLY_W-1:0] start_brake_delay_i,
  input wire logic [`BMS_DLY_W-1:0] stop_brake_delay_i,
  input wire logic fault_clear_i,
  output logic brake_release_request_o,
  output logic [`BMS_N_OUT-1:0] term_out_o,
  output logic hold_freq_o,
  output logic ramp_enable_o,
  output logic output_off_o,
  output logic fault_request_timeout_o,
  output logic fault_release_done_timeout_o,
  output logic fault_release_done_dropped_o,
  output logic restart_inhibit_o,
  output logic param_reject_o
);

  bms_state_rec_t s_reg;
  bms_state_rec_t s_next;
  logic tick, mode_sel, mode_fb, seq_en, done_in;
  logic [`BMS_N_IN-1:0] done_match;
  logic [`BMS_N_OUT-1:0] out_pos;
  logic [`BMS_N_OUT-1:0] out_neg;

  bms_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Terminal mapping

  for (genvar gi = 0; gi < `BMS_N_IN; gi++) begin : g_in
    assign done_match[gi] = (input_terminal_function_select_i[gi*`BMS_FUNC_W +: `BMS_FUNC_W]
                             == `BMS_IN_FUNC_DONE);
  end
  for (genvar gi = 0; gi < `BMS_N_OUT; gi++) begin : g_out
    assign out_pos[gi] = (output_terminal_function_select_i[gi*`BMS_FUNC_W +: `BMS_FUNC_W]
                          == `BMS_OUT_FUNC_POS);
    assign out_neg[gi] = (output_terminal_function_select_i[gi*`BMS_FUNC_W +: `BMS_FUNC_W]
                          == `BMS_OUT_FUNC_NEG);
  end

  assign done_in = |(s_reg.sync2 & done_match);
  assign mode_fb = (ramp_mode_select_i == `BMS_MODE_FEEDBACK);
  assign mode_sel = mode_fb || (ramp_mode_select_i == `BMS_MODE_OPEN);
  assign seq_en = mode_sel && op_mode_valid_i;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = term_in_i;
    s_next.sync2 = s_reg.sync1;
    s_next.reject = 1'b0;
    s_next.restart_inh = mode_sel;
    if (tick) begin
      if (s_reg.tmr != '1) s_next.tmr = s_reg.tmr + 1'b1;
      if (s_reg.ftmr != '1) s_next.ftmr = s_reg.ftmr + 1'b1;
    end
    if (param_load_i) begin
      if (brake_release_freq_i <= brake_engage_freq_i && brake_engage_freq_i <= `BMS_FREQ_MAX
          && brake_release_current_i <= `BMS_CUR_MAX
          && release_current_detect_delay_i <= `BMS_DET_DLY_MAX
          && start_brake_delay_i <= `BMS_BRK_DLY_MAX
          && stop_brake_delay_i <= `BMS_BRK_DLY_MAX) begin
        s_next.rel_freq = brake_release_freq_i;
        s_next.eng_freq = brake_engage_freq_i;
        s_next.rel_cur = brake_release_current_i;
        s_next.det_dly = release_current_detect_delay_i;
        s_next.st_dly = start_brake_delay_i;
        s_next.sp_dly = stop_brake_delay_i;
      end else begin
        s_next.reject = 1'b1;
      end
    end
    unique case (s_reg.state)
      BMS_IDLE: begin
        s_next.off = !start_cmd_i;
        s_next.ramp = start_cmd_i;
        s_next.hold = 1'b0;
        if (start_cmd_i) begin
          s_next.ftmr = '0;
          if (seq_en) s_next.state = BMS_RUN_WAIT;
        end
      end
      BMS_RUN_WAIT, BMS_DETECT: begin
        if (speed_cmd_i >= s_reg.rel_freq) s_next.hold = 1'b1;
        if (s_reg.ftmr >= `BMS_FAULT_TICKS) begin
          s_next.f_req = 1'b1;
          s_next.state = BMS_FAULT;
        end else if (s_reg.state == BMS_RUN_WAIT) begin
          if (speed_cmd_i >= s_reg.rel_freq && out_current_i >= s_reg.rel_cur) begin
            s_next.state = BMS_DETECT;
            s_next.tmr = '0;
          end
        end else if (out_current_i < s_reg.rel_cur) begin
          s_next.state = BMS_RUN_WAIT;
        end else if (s_reg.tmr >= `BMS_TMR_W'(s_reg.det_dly)) begin
          s_next.req = 1'b1;
          s_next.tmr = '0;
          s_next.ftmr = '0;
          s_next.state = mode_fb ? BMS_RELEASE : BMS_START_DLY;
        end
      end
      BMS_RELEASE: begin
        if (done_in) begin
          s_next.tmr = '0;
          s_next.state = BMS_START_DLY;
        end else if (s_reg.ftmr >= `BMS_FAULT_TICKS) begin
          s_next.f_done = 1'b1;
          s_next.state = BMS_FAULT;
        end
      end
      BMS_START_DLY: begin
        if (mode_fb && !done_in) begin
          s_next.f_drop = 1'b1;
          s_next.state = BMS_FAULT;
        end else if (s_reg.tmr >= `BMS_TMR_W'(s_reg.st_dly)) begin
          s_next.hold = 1'b0;
          s_next.state = BMS_RAMP;
        end
      end
      BMS_RAMP: begin
        if (mode_fb && !done_in) begin
          s_next.f_drop = 1'b1;
          s_next.state = BMS_FAULT;
        end else if ((decel_i || !start_cmd_i) && speed_cmd_i <= s_reg.eng_freq) begin
          s_next.req = 1'b0;
          s_next.hold = 1'b1;
          s_next.tmr = '0;
          s_next.state = mode_fb ? BMS_ENGAGE : BMS_STOP_DLY;
        end
      end
      BMS_ENGAGE: begin
        if (!done_in) begin
          s_next.tmr = '0;
          s_next.state = BMS_STOP_DLY;
        end
      end
      BMS_STOP_DLY: begin
        if (s_reg.tmr >= `BMS_TMR_W'(s_reg.sp_dly)) begin
          s_next.state = BMS_OFF;
        end
      end
      BMS_OFF: begin
        if (!start_cmd_i) s_next.state = BMS_IDLE;
      end
      BMS_FAULT: begin
        if (fault_clear_i) begin
          s_next.f_req = 1'b0;
          s_next.f_done = 1'b0;
          s_next.f_drop = 1'b0;
          s_next.state = BMS_IDLE;
        end
      end
    endcase
    if (s_next.state inside {BMS_FAULT, BMS_OFF}) begin
      s_next.off = 1'b1;
      s_next.ramp = 1'b0;
      s_next.hold = 1'b0;
    end
    if (s_next.state != BMS_FAULT && !(s_reg.state inside {BMS_FAULT, BMS_IDLE, BMS_OFF})
        && (!seq_en || (!start_cmd_i && s_reg.state inside {BMS_RUN_WAIT, BMS_DETECT,
        BMS_RELEASE, BMS_START_DLY}))) begin
      s_next.state = BMS_IDLE;
      s_next.off = 1'b1;
      s_next.ramp = 1'b0;
      s_next.hold = 1'b0;
    end
    if (s_next.state inside {BMS_IDLE, BMS_OFF, BMS_FAULT, BMS_RUN_WAIT, BMS_DETECT}) begin
      s_next.req = 1'b0;
    end
    s_next.term_out = (out_pos & {`BMS_N_OUT{s_next.req}})
                      | (out_neg & {`BMS_N_OUT{~s_next.req}});
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
      s_reg.state <= BMS_IDLE;
      s_reg.off <= 1'b1;
      s_reg.term_out <= out_neg;
      s_reg.rel_freq <= `BMS_REL_FREQ_DEF;
      s_reg.eng_freq <= `BMS_ENG_FREQ_DEF;
      s_reg.rel_cur <= `BMS_REL_CUR_DEF;
      s_reg.det_dly <= `BMS_DET_DLY_DEF;
      s_reg.st_dly <= `BMS_BRK_DLY_DEF;
      s_reg.sp_dly <= `BMS_BRK_DLY_DEF;
    end else begin
      s_reg <= s_next;
    end
  end

  assign brake_release_request_o = s_reg.req;
  assign term_out_o = s_reg.term_out;
  assign hold_freq_o = s_reg.hold;
  assign ramp_enable_o = s_reg.ramp;
  assign output_off_o = s_reg.off;
  assign fault_request_timeout_o = s_reg.f_req;
  assign fault_release_done_timeout_o = s_reg.f_done;
  assign fault_release_done_dropped_o = s_reg.f_drop;
  assign restart_inhibit_o = s_reg.restart_inh;
  assign param_reject_o = s_reg.reject;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_detect_done;
    s_reg.state == BMS_DETECT ##1 s_reg.req;
  endsequence

  chk_mode_gate: assert property ($rose(s_reg.req) |-> $past(mode_sel))
    else $error("request raised outside brake sequence mode");
  chk_op_mode_gate: assert property (!op_mode_valid_i |=> !s_reg.req)
    else $error("request held in invalid operation mode");
  chk_out_polarity: assert property (s_reg.term_out[0] == (($past(out_pos[0]) && s_reg.req)
                                     || ($past(out_neg[0]) && !s_reg.req)))
    else $error("output terminal polarity wrong");
  chk_req_after_detect: assert property ($rose(s_reg.req) |-> $past(s_reg.state) == BMS_DETECT
                                         && $past(s_reg.tmr) >= $past(s_reg.det_dly))
    else $error("request raised before detection delay");
  chk_ramp_after_delay: assert property ($fell(s_reg.hold) && s_reg.state == BMS_RAMP
                                         |-> $past(s_reg.tmr) >= $past(s_reg.st_dly))
    else $error("frequency released before start delay");
  chk_engage_drop: assert property (s_reg.state == BMS_RAMP && seq_en && decel_i
                                    && speed_cmd_i <= s_reg.eng_freq |=> !s_reg.req)
    else $error("request not dropped at engage frequency");
  chk_stop_off: assert property (s_reg.state == BMS_STOP_DLY && seq_en
                                 && s_reg.tmr >= `BMS_TMR_W'(s_reg.sp_dly) |=> s_reg.off)
    else $error("output not switched off after stop delay");
  chk_restart_inh: assert property ($past(rstn_i)
                                    |-> restart_inhibit_o == $past(mode_sel))
    else $error("restart inhibit does not follow mode");
  chk_done_drop_trip: assert property (mode_fb && !done_in
                                       && s_reg.state inside {BMS_START_DLY, BMS_RAMP}
                                       |=> s_reg.f_drop && !s_reg.req ##1 s_reg.off)
    else $error("release-done drop not tripped");
  chk_trip_drops_req: assert property (s_reg.state == BMS_FAULT |-> !s_reg.req
                                       && (s_reg.f_req || s_reg.f_done || s_reg.f_drop))
    else $error("request held during trip");
  chk_detect_seq: assert property (seq_detect_done |-> $past(s_reg.tmr) >= $past(s_reg.det_dly))
    else $error("detect sequence too short");

endmodule // bms_brake_seq

/* design/bms_defines.svh */
// Constants of the brake sequencer: codes, defaults, ranges and timing.
// Assumes a 20 MHz clock; settings arrive in tenths of Hz, percent and tenths of seconds.
`ifndef BMS_DEFINES_SVH
`define BMS_DEFINES_SVH

`define BMS_CLK_PERIOD_NS 50
`define BMS_TICK_NS 100000000
`define BMS_TICK_CYCLES (`BMS_TICK_NS / `BMS_CLK_PERIOD_NS)

`define BMS_MODE_W 8
`define BMS_MODE_FEEDBACK 8'h07
`define BMS_MODE_OPEN 8'h08
`define BMS_FUNC_W 8
`define BMS_IN_FUNC_DONE 8'h0f
`define BMS_OUT_FUNC_POS 8'h14
`define BMS_OUT_FUNC_NEG 8'h78
`define BMS_N_IN 7
`define BMS_N_OUT 3

`define BMS_FREQ_W 12
`define BMS_CUR_W 9
`define BMS_DLY_W 6
`define BMS_TMR_W 8

`define BMS_REL_FREQ_DEF 12'h01e
`define BMS_ENG_FREQ_DEF 12'h03c
`define BMS_FREQ_MAX 12'h12c
`define BMS_REL_CUR_DEF 9'h082
`define BMS_CUR_MAX 9'h0c8
`define BMS_DET_DLY_DEF 6'h03
`define BMS_DET_DLY_MAX 6'h14
`define BMS_BRK_DLY_DEF 6'h03
`define BMS_BRK_DLY_MAX 6'h32
`define BMS_FAULT_TICKS 8'h14

`endif

/* design/bms_pkg.sv */
// Types of the brake sequencer: sequence states and the state record.
// Assumes bms_defines.svh is on the include path.
`include "bms_defines.svh"

package bms_pkg;

  typedef enum logic [3:0] {
    BMS_IDLE, BMS_RUN_WAIT, BMS_DETECT, BMS_RELEASE, BMS_START_DLY,
    BMS_RAMP, BMS_ENGAGE, BMS_STOP_DLY, BMS_OFF, BMS_FAULT
  } bms_state_t;

  typedef struct packed {
    bms_state_t state;
    logic [`BMS_TMR_W-1:0] tmr;
    logic [`BMS_TMR_W-1:0] ftmr;
    logic [`BMS_FREQ_W-1:0] rel_freq;
    logic [`BMS_FREQ_W-1:0] eng_freq;
    logic [`BMS_CUR_W-1:0] rel_cur;
    logic [`BMS_DLY_W-1:0] det_dly;
    logic [`BMS_DLY_W-1:0] st_dly;
    logic [`BMS_DLY_W-1:0] sp_dly;
    logic req;
    logic hold;
    logic ramp;
    logic off;
    logic f_req;
    logic f_done;
    logic f_drop;
    logic reject;
    logic restart_inh;
    logic [`BMS_N_OUT-1:0] term_out;
    logic [`BMS_N_IN-1:0] sync1;
    logic [`BMS_N_IN-1:0] sync2;
  } bms_state_rec_t;

endpackage

/* design/bms_tick_gen.sv */
// Time-base divider: one-cycle tick every CYCLES clocks.
// Assumes a single clock with synchronous active-low reset.
`timescale 1ns/1ps

module bms_tick_gen #(
  parameter int unsigned CYCLES = 2000000
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  output logic tick_o
);

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  logic tick_reg;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end
  end

  assign tick_o = tick_reg;

endmodule // bms_tick_gen

/* dv/bms_brake_model.sv */
// Model of the mechanical brake and its release-completion contact.
// Assumes the request arrives as a positive level on a mapped output terminal.
`timescale 1ns/1ps

module bms_brake_model #(
  parameter int DLY = 15
) (
  input wire logic clock_i,
  input wire logic req_i,
  input wire logic mute_i,
  input wire logic drop_i,
  output logic done_o
);
  int cnt = 0;
  logic pos = 1'b0;

  // Contact follows the request after a mechanical delay; mute holds it open
  always @(posedge clock_i) begin
    if (req_i !== pos && !(req_i && mute_i)) begin
      cnt <= cnt + 1;
      if (cnt >= DLY) begin
        pos <= req_i;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end

  // Drop opens the contact while the brake is still released
  assign done_o = pos & ~drop_i;
endmodule // bms_brake_model

/* dv/bms_brake_seq_tb.sv */
// Self-checking bench of the brake sequencer with a brake model.
// Assumes a tick of 10 clocks; settings at their reset defaults unless loaded.
`include "bms_defines.svh"
`timescale 1ns/1ps

module bms_brake_seq_tb;
  logic clock_i, rstn_i, op_valid, start, decel, pload, fclr, mute, drop, done;
  logic [7:0] mode;
  logic [11:0] spd, rf, ef;
  logic [8:0] cur, rc;
  logic [5:0] dd, sd, pd;
  logic req, hold, ramp, off, f_req, f_tmo, f_drop, rinh, rej;
  logic [2:0] tout;
  int err_total = 0;
  int checks = 0;
  int n;

  bms_brake_seq #(.TICK_CYCLES(10)) u_dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .ramp_mode_select_i(mode), .op_mode_valid_i(op_valid), .start_cmd_i(start),
    .decel_i(decel), .speed_cmd_i(spd), .out_current_i(cur),
    .term_in_i({3'b000, done, 3'b000}),
    .input_terminal_function_select_i({24'h0, 8'h0f, 24'h0}),
    .output_terminal_function_select_i({8'h00, 8'h14, 8'h78}),
    .param_load_i(pload), .brake_release_freq_i(rf), .brake_engage_freq_i(ef),
    .brake_release_current_i(rc), .release_current_detect_delay_i(dd),
    .start_brake_delay_i(sd), .stop_brake_delay_i(pd), .fault_clear_i(fclr),
    .brake_release_request_o(req), .term_out_o(tout), .hold_freq_o(hold),
    .ramp_enable_o(ramp), .output_off_o(off), .fault_request_timeout_o(f_req),
    .fault_release_done_timeout_o(f_tmo), .fault_release_done_dropped_o(f_drop),
    .restart_inhibit_o(rinh), .param_reject_o(rej));

  bms_brake_model #(.DLY(15)) u_brake (.clock_i(clock_i), .req_i(tout[1]),
    .mute_i(mute), .drop_i(drop), .done_o(done));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic wait_sig(ref logic s, input logic lvl, input int max, output int k);
    k = 0;
    while (s !== lvl) begin
      if (k == max) begin
        err_total++;
        $display("[FAIL] %0t wait timed out", $time);
        complete_run();
      end
      @(negedge clock_i);
      k++;
    end
  endtask

  task automatic rng(input int k, input int lo, input int hi, input string m);
    check({15'h0, k >= lo && k <= hi}, 16'h1, m);
  endtask

  task automatic load(input logic [11:0] a, b, input logic [8:0] c,
                      input logic [5:0] d, e, f, input logic exp);
    logic r0;
    {rf, ef, rc, dd, sd, pd} = {a, b, c, d, e, f};
    pload = 1'b1;
    @(negedge clock_i);
    pload = 1'b0;
    r0 = rej;
    @(negedge clock_i);
    check({15'h0, r0 | rej}, {15'h0, exp}, "setting reject");
  endtask

  task automatic clear_fault();
    start = 1'b0;
    mute = 1'b0;
    drop = 1'b0;
    fclr = 1'b1;
    @(negedge clock_i);
    fclr = 1'b0;
    repeat (40) @(negedge clock_i);
    check({13'h0, f_req, f_tmo, f_drop}, 16'h0, "fault flags cleared");
  endtask

  // Full start and stop; the contact answer adds about 20 clocks in mode 7
  task automatic run_seq(input logic [7:0] m);
    int w;
    w = (m == 8'h07) ? 15 : 0;
    mode = m;
    start = 1'b1;
    wait_sig(req, 1'b1, 80, n);
    rng(n, 20, 40, "request after detect delay");
    check({13'h0, tout}, 16'h2, "terminal mapping on");
    check({15'h0, hold}, 16'h1, "frequency held");
    wait_sig(hold, 1'b0, 100, n);
    rng(n, 20 + w, 35 + w + 5, "start brake delay");
    check({15'h0, ramp}, 16'h1, "ramp after release");
    // Speed only steps inside the brake band, standing in for a ramp of 1 s or more
    spd = 12'h03c;
    decel = 1'b1;
    wait_sig(req, 1'b0, 5, n);
    check({13'h0, tout}, 16'h1, "terminal mapping off");
    wait_sig(off, 1'b1, 100, n);
    rng(n, 20 + w, 35 + w + 5, "stop brake delay");
    start = 1'b0;
    decel = 1'b0;
    spd = 12'h01e;
    repeat (30) @(negedge clock_i);
  endtask

  task automatic no_seq(input logic [7:0] m, input logic v);
    mode = m;
    op_valid = v;
    start = 1'b1;
    repeat (80) @(negedge clock_i);
    check({14'h0, req, ramp}, 16'h1, "plain run without request");
    start = 1'b0;
    op_valid = 1'b1;
    repeat (5) @(negedge clock_i);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn_i, op_valid, start, decel, pload, fclr, mute, drop} = 8'h00;
    {mode, spd, cur} = {8'h00, 12'h01e, 9'h082};
    {rf, ef, rc, dd, sd, pd} = {12'h01e, 12'h03c, 9'h082, 6'h03, 6'h03, 6'h03};
    repeat (4) @(negedge clock_i);
    rstn_i = 1'b1;
    op_valid = 1'b1;
    @(negedge clock_i);
    check({8'h0, tout, req, off, f_req, f_tmo, f_drop}, 16'h28, "reset outputs");
    for (int i = 0; i < 3; i++) begin
      mode = (i == 0) ? 8'h00 : 8'h06 + 8'(i);
      repeat (2) @(negedge clock_i);
      check({15'h0, rinh}, {15'h0, i != 0}, "restart inhibit");
    end
    no_seq(8'h00, 1'b1);
    no_seq(8'h08, 1'b0);
    // Defaults give 3 Hz, 130 percent and 0.3 s, met exactly
    run_seq(8'h08);
    run_seq(8'h07);
    load(12'h03d, 12'h03c, 9'h082, 6'h03, 6'h03, 6'h03, 1'b1);
    load(12'h01e, 12'h12d, 9'h082, 6'h03, 6'h03, 6'h03, 1'b1);
    load(12'h01e, 12'h03c, 9'h0c9, 6'h03, 6'h03, 6'h03, 1'b1);
    load(12'h01e, 12'h03c, 9'h082, 6'h15, 6'h03, 6'h03, 1'b1);
    load(12'h01e, 12'h03c, 9'h082, 6'h03, 6'h33, 6'h03, 1'b1);
    load(12'h01e, 12'h03c, 9'h082, 6'h03, 6'h03, 6'h33, 1'b1);
    load(12'h03c, 12'h03c, 9'h0c8, 6'h03, 6'h03, 6'h03, 1'b0);
    load(12'h01e, 12'h03c, 9'h082, 6'h03, 6'h03, 6'h03, 1'b0);
    mode = 8'h08;
    cur = 9'h081;
    start = 1'b1;
    wait_sig(f_req, 1'b1, 260, n);
    rng(n, 185, 215, "request timeout");
    check({14'h0, req, off}, 16'h1, "trip drops request");
    clear_fault();
    cur = 9'h082;
    mode = 8'h07;
    mute = 1'b1;
    start = 1'b1;
    wait_sig(req, 1'b1, 80, n);
    wait_sig(f_tmo, 1'b1, 260, n);
    rng(n, 185, 215, "release done timeout");
    check({14'h0, req, off}, 16'h1, "trip drops request");
    clear_fault();
    start = 1'b1;
    wait_sig(req, 1'b1, 80, n);
    wait_sig(hold, 1'b0, 100, n);
    drop = 1'b1;
    wait_sig(f_drop, 1'b1, 10, n);
    check({14'h0, req, off}, 16'h1, "trip drops request");
    clear_fault();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    complete_run();
  end
endmodule // bms_brake_seq_tb
